// file: inc/csi_pkg.sv
// shared constants of the charger status indication block
package csi_pkg;

  // register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_TSWIN = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;

  // control register fields
  localparam int CTRL_CHG_CFG = 0;
  localparam int CTRL_DIRECT = 1;
  localparam int CTRL_IND_LO = 2;
  localparam int CTRL_DP_LO = 4;
  localparam int CTRL_DM_LO = 6;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;

  // indicator selection codes
  localparam logic [1:0] IND_SEL_ON = 2'h0;

  // thermistor window fields
  localparam int TSWIN_LO = 0;
  localparam int TSWIN_HI = 8;
  localparam logic [31:0] TSWIN_RST = 32'h0000_d020;

  // status register fields
  localparam int STAT_CHG_EN = 0;
  localparam int STAT_TS_OUT = 1;
  localparam int STAT_ALERT = 2;
  localparam int STAT_ALLOW_N = 3;
  localparam int STAT_IND = 4;
  localparam int STAT_CODE_LO = 8;

  // timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned ALERT_PULSE_US = 256;
  localparam int unsigned ALERT_CYCLES = ALERT_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BLINK_HZ = 1;
  localparam int unsigned BLINK_HALF_CYCLES = CLK_HZ / (2 * BLINK_HZ);

  typedef enum {IND_RELEASE, IND_LOW, IND_BLINK} csi_ind_t;

endpackage

// file: hdl/csi_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module csi_sync #(
  parameter int W = 1,
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= {W{RST_VAL}};
      sync_ff <= {W{RST_VAL}};
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;
endmodule
`default_nettype wire

// file: hdl/csi_interval.sv
// restartable interval counter that ticks every LIMIT cycles while running
`timescale 1ns/1ps
`default_nettype none
module csi_interval #(
  parameter int unsigned LIMIT = 16,
  parameter int W = $clog2(LIMIT + 1)
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic run,
  // state
  output logic [W-1:0] cnt,
  output logic tick
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  assign tick = run && !start && (cnt_ff == W'(LIMIT - 1));

  always_comb begin
    nxt_cnt = cnt_ff;
    if (start) begin
      nxt_cnt = '0;
    end else if (tick) begin
      nxt_cnt = '0;
    end else if (run) begin
      nxt_cnt = cnt_ff + W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign cnt = cnt_ff;
endmodule
`default_nettype wire

// file: hdl/csi_top.sv
// charger status indication: status pin, host alert, charge gating, apb registers
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module csi_top #(
  parameter int unsigned ALERT_CYCLES = csi_pkg::ALERT_CYCLES,
  parameter int unsigned BLINK_HALF_CYCLES = csi_pkg::BLINK_HALF_CYCLES
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_B,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // charger core state
  input wire logic CHG_ACTIVE,
  input wire logic CHG_FAULT,
  input wire logic STATUS_UPDATE,
  input wire logic [7:0] THERMISTOR_SENSE_IN,
  // charge enable pin
  input wire logic CHARGE_ALLOW_IN_N,
  // status indicator pin, open drain
  output logic STAT_O,
  output logic STAT_OE_N,
  // host alert pin, open drain
  output logic HOST_ALERT_OUT_N_O,
  output logic HOST_ALERT_OUT_N_OE_N,
  // charge control
  output logic CHARGE_EN,
  output logic CHARGE_SUSPEND,
  output logic DIRECT_PATH_ENABLE_OUT,
  output logic [1:0] DPLUS_LEVEL_SEL,
  output logic [1:0] DMINUS_LEVEL_SEL
);

  ////////////////////////////////////////////////////////////////////////////
  // apb register access

  logic [31:0] ctrl_ff;
  logic [31:0] nxt_ctrl;
  logic [31:0] tswin_ff;
  logic [31:0] nxt_tswin;
  logic pready_ff;
  logic nxt_pready;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic acc_done;
  logic wr_ctrl;
  logic wr_tswin;
  logic addr_hit;
  logic [31:0] status_word;

  assign acc_done = PSEL && PENABLE && pready_ff;
  assign addr_hit = (PADDR == csi_pkg::ADDR_CTRL) || (PADDR == csi_pkg::ADDR_TSWIN) ||
                    (PADDR == csi_pkg::ADDR_STATUS);
  assign wr_ctrl = acc_done && PWRITE && (PADDR == csi_pkg::ADDR_CTRL);
  assign wr_tswin = acc_done && PWRITE && (PADDR == csi_pkg::ADDR_TSWIN);

  always_comb begin
    nxt_pready = PSEL && PENABLE && !pready_ff;
    nxt_prdata = '0;
    nxt_pslverr = 1'b0;
    if (PSEL && PENABLE && !pready_ff) begin
      nxt_pslverr = !addr_hit;
      if (!PWRITE) begin
        unique case (PADDR)
          csi_pkg::ADDR_CTRL: nxt_prdata = ctrl_ff;
          csi_pkg::ADDR_TSWIN: nxt_prdata = tswin_ff;
          csi_pkg::ADDR_STATUS: nxt_prdata = status_word;
          default: nxt_prdata = '0;
        endcase
      end
    end
  end

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_tswin = tswin_ff;
    if (wr_ctrl) begin
      nxt_ctrl = {24'h00_0000, PWDATA[7:0]};
    end
    if (wr_tswin) begin
      nxt_tswin = {16'h0000, PWDATA[15:0]};
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_ff <= csi_pkg::CTRL_RST;
      tswin_ff <= csi_pkg::TSWIN_RST;
      pready_ff <= 1'b0;
      prdata_ff <= '0;
      pslverr_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      tswin_ff <= nxt_tswin;
      pready_ff <= nxt_pready;
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // charge gating and thermistor window

  logic allow_n_s;
  logic ts_out;
  logic ind_on;
  logic chg_cfg;

  csi_sync #(.W(1), .RST_VAL(1'b1)) u_allow_sync (
    .clk(MCLK),
    .rst_n(RST_B),
    .d(CHARGE_ALLOW_IN_N),
    .q(allow_n_s)
  );

  assign chg_cfg = ctrl_ff[csi_pkg::CTRL_CHG_CFG];
  assign ind_on = ctrl_ff[csi_pkg::CTRL_IND_LO +: 2] == csi_pkg::IND_SEL_ON;
  assign ts_out = (THERMISTOR_SENSE_IN < tswin_ff[csi_pkg::TSWIN_LO +: 8]) ||
                  (THERMISTOR_SENSE_IN > tswin_ff[csi_pkg::TSWIN_HI +: 8]);

  ////////////////////////////////////////////////////////////////////////////
  // status indicator blink and host alert timing

  logic fault_d_ff;
  logic ts_d_ff;
  logic fault_rise;
  logic alert_trig;
  logic blink_tick;
  logic alert_tick;
  logic [$clog2(BLINK_HALF_CYCLES + 1)-1:0] blink_cnt;
  logic blink_lo_ff;
  logic nxt_blink_lo;
  logic alert_ff;
  logic nxt_alert;
  csi_pkg::csi_ind_t ind_mode;

  assign fault_rise = CHG_FAULT && !fault_d_ff;
  assign alert_trig = STATUS_UPDATE || fault_rise || (ts_out && !ts_d_ff);

  csi_interval #(.LIMIT(BLINK_HALF_CYCLES)) u_blink (
    .clk(MCLK),
    .rst_n(RST_B),
    .start(fault_rise),
    .run(CHG_FAULT),
    .cnt(blink_cnt),
    .tick(blink_tick)
  );

  csi_interval #(.LIMIT(ALERT_CYCLES)) u_alert (
    .clk(MCLK),
    .rst_n(RST_B),
    .start(alert_trig),
    .run(alert_ff),
    .cnt(),
    .tick(alert_tick)
  );

  always_comb begin
    nxt_blink_lo = blink_lo_ff;
    if (fault_rise) begin
      nxt_blink_lo = 1'b1;
    end else if (blink_tick) begin
      nxt_blink_lo = !blink_lo_ff;
    end
    nxt_alert = alert_ff;
    if (alert_trig) begin
      nxt_alert = 1'b1;
    end else if (alert_tick) begin
      nxt_alert = 1'b0;
    end
    if (CHG_FAULT) begin
      ind_mode = csi_pkg::IND_BLINK;
    end else if (CHG_ACTIVE && CHARGE_EN) begin
      ind_mode = csi_pkg::IND_LOW;
    end else begin
      ind_mode = csi_pkg::IND_RELEASE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output registers

  logic stat_oe_n_ff;
  logic nxt_stat_oe_n;
  logic chg_en_ff;
  logic nxt_chg_en;

  always_comb begin
    unique case (ind_mode)
      csi_pkg::IND_LOW: nxt_stat_oe_n = 1'b0;
      csi_pkg::IND_BLINK: nxt_stat_oe_n = !nxt_blink_lo;
      csi_pkg::IND_RELEASE: nxt_stat_oe_n = 1'b1;
    endcase
    if (!ind_on) begin
      nxt_stat_oe_n = 1'b1;
    end
    nxt_chg_en = chg_cfg && !allow_n_s && !ts_out;
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      fault_d_ff <= 1'b0;
      ts_d_ff <= 1'b0;
      blink_lo_ff <= 1'b0;
      alert_ff <= 1'b0;
      stat_oe_n_ff <= 1'b1;
      chg_en_ff <= 1'b0;
    end else begin
      fault_d_ff <= CHG_FAULT;
      ts_d_ff <= ts_out;
      blink_lo_ff <= nxt_blink_lo;
      alert_ff <= nxt_alert;
      stat_oe_n_ff <= nxt_stat_oe_n;
      chg_en_ff <= nxt_chg_en;
    end
  end

  assign status_word = {16'h0000, THERMISTOR_SENSE_IN, 3'h0, !stat_oe_n_ff, allow_n_s,
                        alert_ff, ts_d_ff, chg_en_ff};

  assign PRDATA = prdata_ff;
  assign PREADY = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign STAT_O = 1'b0;
  assign STAT_OE_N = stat_oe_n_ff;
  assign HOST_ALERT_OUT_N_O = 1'b0;
  assign HOST_ALERT_OUT_N_OE_N = !alert_ff;
  assign CHARGE_EN = chg_en_ff;
  assign CHARGE_SUSPEND = ts_d_ff;
  assign DIRECT_PATH_ENABLE_OUT = ctrl_ff[csi_pkg::CTRL_DIRECT];
  assign DPLUS_LEVEL_SEL = ctrl_ff[csi_pkg::CTRL_DP_LO +: 2];
  assign DMINUS_LEVEL_SEL = ctrl_ff[csi_pkg::CTRL_DM_LO +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [31:0] alert_len_ff;

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      alert_len_ff <= '0;
    end else if (alert_trig) begin
      alert_len_ff <= 32'h0000_0001;
    end else if (!HOST_ALERT_OUT_N_OE_N) begin
      alert_len_ff <= alert_len_ff + 32'h0000_0001;
    end else begin
      alert_len_ff <= '0;
    end
  end

  property p_stat_low;
    @(posedge MCLK) disable iff (!RST_B)
      ind_on && !CHG_FAULT && CHG_ACTIVE && CHARGE_EN |=> !STAT_OE_N;
  endproperty
  a_stat_low: assert property (p_stat_low) else $error("status pin not low while charging");

  property p_stat_release;
    @(posedge MCLK) disable iff (!RST_B)
      !CHG_FAULT && !(CHG_ACTIVE && CHARGE_EN) |=> STAT_OE_N;
  endproperty
  a_stat_release: assert property (p_stat_release) else $error("status pin not released");

  property p_blink_toggle;
    @(posedge MCLK) disable iff (!RST_B)
      ind_on && CHG_FAULT && blink_tick && $past(ind_on) && $past(CHG_FAULT)
      |=> STAT_OE_N != $past(STAT_OE_N);
  endproperty
  a_blink_toggle: assert property (p_blink_toggle) else $error("blink did not toggle");

  property p_stat_off;
    @(posedge MCLK) disable iff (!RST_B)
      !ind_on && !wr_ctrl |=> STAT_OE_N [*2];
  endproperty
  a_stat_off: assert property (p_stat_off) else $error("indicator driven while off");

  property p_alert_width;
    @(posedge MCLK) disable iff (!RST_B)
      $rose(HOST_ALERT_OUT_N_OE_N) |-> $past(alert_len_ff) == 32'(ALERT_CYCLES);
  endproperty
  a_alert_width: assert property (p_alert_width) else $error("alert pulse width wrong");

  property p_alert_start;
    @(posedge MCLK) disable iff (!RST_B)
      alert_trig |=> !HOST_ALERT_OUT_N_OE_N;
  endproperty
  a_alert_start: assert property (p_alert_start) else $error("alert not asserted");

  property p_open_drain;
    @(posedge MCLK) disable iff (!RST_B)
      !HOST_ALERT_OUT_N_O && !STAT_O;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain pin driven high");

  property p_charge_gate;
    @(posedge MCLK) disable iff (!RST_B)
      (!chg_cfg || allow_n_s) |=> !CHARGE_EN;
  endproperty
  a_charge_gate: assert property (p_charge_gate) else $error("charge enabled while inhibited");

  property p_direct;
    @(posedge MCLK) disable iff (!RST_B)
      wr_ctrl |=> DIRECT_PATH_ENABLE_OUT == $past(PWDATA[csi_pkg::CTRL_DIRECT]);
  endproperty
  a_direct: assert property (p_direct) else $error("direct path enable not updated");

  property p_ts_suspend;
    @(posedge MCLK) disable iff (!RST_B)
      ts_out |=> CHARGE_SUSPEND && !CHARGE_EN;
  endproperty
  a_ts_suspend: assert property (p_ts_suspend) else $error("no suspend outside window");

  property p_levels;
    @(posedge MCLK) disable iff (!RST_B)
      wr_ctrl |=> DPLUS_LEVEL_SEL == $past(PWDATA[5:4]) && DMINUS_LEVEL_SEL == $past(PWDATA[7:6]);
  endproperty
  a_levels: assert property (p_levels) else $error("data line levels not updated");

  property p_blink_restart;
    @(posedge MCLK) disable iff (!RST_B)
      fault_rise ##1 CHG_FAULT |-> blink_cnt == '0 ##1 blink_cnt == 1;
  endproperty
  a_blink_restart: assert property (p_blink_restart) else $error("blink count not restarted");

  cover property (@(posedge MCLK) disable iff (!RST_B) $rose(HOST_ALERT_OUT_N_OE_N));
  cover property (@(posedge MCLK) disable iff (!RST_B) ind_on && CHG_FAULT && blink_tick);
  cover property (@(posedge MCLK) disable iff (!RST_B) wr_ctrl);
  cover property (@(posedge MCLK) disable iff (!RST_B) $rose(CHARGE_SUSPEND));

endmodule
`default_nettype wire

// file: sim/csi_host.sv
// host side model: pulled-up status and alert pins, alert pulse meter
`timescale 1ns/1ps
`default_nettype none
module csi_host (
  // clock
  input wire logic clk,
  // open-drain pins
  input wire logic stat_o,
  input wire logic stat_oe_n,
  input wire logic alert_o,
  input wire logic alert_oe_n,
  // observed levels and alert pulse meter
  output logic stat_pin,
  output logic alert_pin,
  output int pulses,
  output int last_width
);
  int width;
  // pull-ups: a released pin reads high
  assign stat_pin = stat_oe_n ? 1'b1 : stat_o;
  assign alert_pin = alert_oe_n ? 1'b1 : alert_o;
  initial begin
    width = 0;
    pulses = 0;
    last_width = 0;
  end
  always @(posedge clk) begin
    if (alert_pin !== 1'b1) begin
      width <= width + 1;
    end else begin
      if (width != 0) begin
        pulses <= pulses + 1;
        last_width <= width;
      end
      width <= 0;
    end
  end
endmodule
`default_nettype wire

// file: sim/charger_status_indication_bench.sv
// self-checking bench of the charger status indication block
`timescale 1ns/1ps
`default_nettype none
module charger_status_indication_bench;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic act = 1'b0;
  logic fault = 1'b0;
  logic upd = 1'b0;
  logic [7:0] therm = 8'h80;
  logic allow_n = 1'b1;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, st_o, st_oe_n, al_o, al_oe_n, chg_en, susp, direct;
  wire logic [1:0] dp, dm;
  wire logic stat_pin, alert_pin;
  int pulses, last_width, p;
  int n_errors = 0;
  int tests_run = 0;
  logic [31:0] rd;
  logic er;
  always #5 mclk = ~mclk;
  csi_top #(.ALERT_CYCLES(8), .BLINK_HALF_CYCLES(5)) u_csi_top (.MCLK(mclk), .RST_B(rst_b),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CHG_ACTIVE(act),
    .CHG_FAULT(fault), .STATUS_UPDATE(upd), .THERMISTOR_SENSE_IN(therm),
    .CHARGE_ALLOW_IN_N(allow_n), .STAT_O(st_o), .STAT_OE_N(st_oe_n),
    .HOST_ALERT_OUT_N_O(al_o), .HOST_ALERT_OUT_N_OE_N(al_oe_n), .CHARGE_EN(chg_en),
    .CHARGE_SUSPEND(susp), .DIRECT_PATH_ENABLE_OUT(direct), .DPLUS_LEVEL_SEL(dp),
    .DMINUS_LEVEL_SEL(dm));
  csi_host u_csi_host (.clk(mclk), .stat_o(st_o), .stat_oe_n(st_oe_n), .alert_o(al_o),
    .alert_oe_n(al_oe_n), .stat_pin(stat_pin), .alert_pin(alert_pin), .pulses(pulses),
    .last_width(last_width));
  //////////////////////////////////////////////////////////////////////////////////////////
  task test_done;
    if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      test_done;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    chk(stat_pin, 1'b1);
    chk(alert_pin, 1'b1);
    chk(chg_en, 1'b0);
    apb(1'b0, csi_pkg::ADDR_CTRL, 32'h0);
    chk(rd, csi_pkg::CTRL_RST);
    apb(1'b0, csi_pkg::ADDR_TSWIN, 32'h0);
    chk(rd, csi_pkg::TSWIN_RST);
  endtask
  task t_gate;
    logic [7:0] tv [4];
    tv = '{8'h1f, 8'h20, 8'hd0, 8'hd1};
    @(posedge mclk);
    allow_n <= 1'b0;
    wait_n(6);
    chk(chg_en, 1'b1);
    apb(1'b1, csi_pkg::ADDR_CTRL, 32'h0);
    wait_n(3);
    chk(chg_en, 1'b0);
    apb(1'b1, csi_pkg::ADDR_CTRL, 32'h1);
    @(posedge mclk);
    allow_n <= 1'b1;
    wait_n(6);
    chk(chg_en, 1'b0);
    allow_n <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      therm <= tv[i];
      wait_n(6);
      chk(susp, (i == 0 || i == 3));
      chk(chg_en, (i == 1 || i == 2));
    end
    therm <= 8'h80;
    wait_n(3);
  endtask
  task t_stat;
    act <= 1'b1;
    wait_n(3);
    chk(stat_pin, 1'b0);
    apb(1'b1, csi_pkg::ADDR_CTRL, 32'h5);
    wait_n(3);
    chk(stat_pin, 1'b1);
    apb(1'b1, csi_pkg::ADDR_CTRL, 32'h1);
    wait_n(3);
    chk(stat_pin, 1'b0);
    act <= 1'b0;
    wait_n(3);
    chk(stat_pin, 1'b1);
  endtask
  task t_blink;
    int i;
    wait_n(20);
    p = pulses;
    fault <= 1'b1;
    i = 0;
    while (stat_pin !== 1'b0 && i < 10) begin
      wait_n(1);
      i++;
    end
    if (stat_pin !== 1'b0) begin
      n_errors++;
      test_done;
    end
    for (int j = 0; j < 20; j++) begin
      chk(stat_pin, (j / 5) % 2);
      wait_n(1);
    end
    fault <= 1'b0;
    wait_n(3);
    chk(stat_pin, 1'b1);
    chk(pulses, p + 1);
  endtask
  task t_alert;
    wait_n(20);
    p = pulses;
    upd <= 1'b1;
    @(posedge mclk);
    upd <= 1'b0;
    wait_n(15);
    chk(pulses, p + 1);
    chk(last_width, 8);
    upd <= 1'b1;
    @(posedge mclk);
    upd <= 1'b0;
    repeat (3) @(posedge mclk);
    upd <= 1'b1;
    @(posedge mclk);
    upd <= 1'b0;
    wait_n(20);
    chk(pulses, p + 2);
    chk(last_width, 12);
    chk(al_o, 1'b0);
  endtask
  task t_regs;
    logic [1:0] v;
    logic [31:0] d;
    for (int i = 0; i < 4; i++) begin
      v = i[1:0];
      d = {24'h0, ~v, v, 2'b00, v[0], 1'b1};
      apb(1'b1, csi_pkg::ADDR_CTRL, d);
      wait_n(2);
      chk(dp, v);
      chk(dm, d[7:6]);
      chk(direct, v[0]);
      apb(1'b0, csi_pkg::ADDR_CTRL, 32'h0);
      chk(rd, d);
    end
    apb(1'b0, 12'h00c, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(1'b0, csi_pkg::ADDR_STATUS, 32'h0);
    chk(rd, (32'h80 << csi_pkg::STAT_CODE_LO) | (32'h1 << csi_pkg::STAT_CHG_EN));
    apb(1'b1, csi_pkg::ADDR_CTRL, 32'h1);
  endtask
  //////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    wait_n(2);
    t_reset;
    t_gate;
    t_stat;
    t_blink;
    t_alert;
    t_regs;
    test_done;
  end
endmodule
`default_nettype wire
